// ### design/serial_shift_latch_sink_driver.sv
// shift register, storage latch and open-drain sink outputs
`timescale 1ns/10ps
`include "sink_driver_defines.svh"
//
// Overview of operation
// - twelve shift stages feed a twelve-bit storage register in parallel
// - shift clock rising edge loads serial input, advances the other stages
// - latch clock rising edge copies all shift stages into storage
// - clear low zeroes shift register, storage and output buffer
// - storage reaches the output buffer only while clear is high
// - output enable high keeps every output buffer bit low
// - output enable low lets the output buffer follow the storage register
// - buffer bit one makes its sink conduct, zero leaves it off
// - serial output shows last stage and changes only on shift clock fall or while clear is low
// - serial output comes from the final of the twelve stages
// - serial input reaches serial output a half period after its last shift
// - over-temperature forces all sinks off until the indication clears
module serial_shift_latch_sink_driver #(
    parameter int STAGES = `SSL_STAGES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic shift_clock,
    input wire logic latch_clock,
    input wire logic clear_n,
    input wire logic output_enable_n,
    input wire logic serial_in,
    input wire logic over_temp,
    output logic [STAGES-1:0] sink_out,
    output logic [STAGES-1:0] sink_oe_n,
    output logic serial_out,
    output logic shift_ready
);
    sink_driver_pkg::pin_sample_t pin_raw, pin_meta, pin_sync, pin_prev;
    sink_driver_pkg::pin_sample_t next_meta, next_sync, next_prev;
    sink_driver_pkg::thermal_state_t thermal, next_thermal;
    logic [STAGES-1:0] shift_reg, next_shift_reg;
    logic [STAGES-1:0] storage, next_storage;
    logic [STAGES-1:0] sink_on, next_sink_on;
    logic next_serial_out, next_shift_ready;
    logic shift_rise, shift_fall, latch_rise;
    logic buf_in_ready, buf_out_valid, buf_out_ready, pop;
    logic [0:0] buf_out_data;

    assign pin_raw = '{shift_clock: shift_clock, latch_clock: latch_clock,
                       clear_n: clear_n, output_enable_n: output_enable_n,
                       serial_in: serial_in, over_temp: over_temp};

    // every pin passes two flops; edges are found on the second and a third
    always_comb
    begin
        next_meta = pin_raw;
        next_sync = pin_meta;
        next_prev = pin_sync;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pin_meta <= `SSL_SYNC_RESET;
            pin_sync <= `SSL_SYNC_RESET;
            pin_prev <= `SSL_SYNC_RESET;
        end
        else
        begin
            pin_meta <= next_meta;
            pin_sync <= next_sync;
            pin_prev <= next_prev;
        end
    end

    assign shift_rise = pin_sync.shift_clock & ~pin_prev.shift_clock;
    assign shift_fall = ~pin_sync.shift_clock & pin_prev.shift_clock;
    assign latch_rise = pin_sync.latch_clock & ~pin_prev.latch_clock;

    // a latch copy takes the stages as they stand, so a pending shift waits one cycle
    assign buf_out_ready = ~latch_rise;
    assign pop = buf_out_valid & buf_out_ready;

    pair_buffer #(
        .WIDTH(1),
        .DEPTH(`SSL_BUFFER_DEPTH)
    ) shift_events (
        .clock(clock),
        .rst(rst),
        .flush(~pin_sync.clear_n),
        .in_valid(shift_rise & pin_sync.clear_n),
        .in_data(pin_sync.serial_in),
        .in_ready(buf_in_ready),
        .out_valid(buf_out_valid),
        .out_data(buf_out_data),
        .out_ready(buf_out_ready)
    );

    always_comb
    begin
        next_thermal = thermal;
        unique case (thermal)
            sink_driver_pkg::THERMAL_RUN:
            begin
                if (pin_sync.over_temp)
                begin
                    next_thermal = sink_driver_pkg::THERMAL_SHUTDOWN;
                end
            end
            sink_driver_pkg::THERMAL_SHUTDOWN:
            begin
                // the sensor supplies the hysteresis; release follows its flag
                if (!pin_sync.over_temp)
                begin
                    next_thermal = sink_driver_pkg::THERMAL_RUN;
                end
            end
        endcase
    end

    always_comb
    begin
        next_shift_reg = shift_reg;
        next_storage = storage;
        next_serial_out = serial_out;
        if (pop)
        begin
            next_shift_reg = {shift_reg[STAGES-2:0], buf_out_data[0]};
        end
        if (latch_rise)
        begin
            next_storage = shift_reg;
        end
        if (shift_fall)
        begin
            next_serial_out = shift_reg[STAGES-1];
        end
        if (!pin_sync.clear_n)
        begin
            next_shift_reg = `SSL_SHIFT_RESET;
            next_storage = `SSL_STORE_RESET;
            next_serial_out = `SSL_SERIAL_RESET;
        end
        // the output buffer is one flop behind the synchronised pins, no extra clock edge needed
        if (!pin_sync.clear_n || pin_sync.output_enable_n
            || next_thermal == sink_driver_pkg::THERMAL_SHUTDOWN)
        begin
            next_sink_on = '0;
        end
        else
        begin
            next_sink_on = next_storage;
        end
        next_shift_ready = buf_in_ready;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            thermal <= sink_driver_pkg::THERMAL_RUN;
            shift_reg <= `SSL_SHIFT_RESET;
            storage <= `SSL_STORE_RESET;
            sink_on <= '0;
            sink_oe_n <= '1;
            sink_out <= '0;
            serial_out <= `SSL_SERIAL_RESET;
            shift_ready <= 1'b1;
        end
        else
        begin
            thermal <= next_thermal;
            shift_reg <= next_shift_reg;
            storage <= next_storage;
            sink_on <= next_sink_on;
            sink_oe_n <= ~next_sink_on;
            sink_out <= '0;
            serial_out <= next_serial_out;
            shift_ready <= next_shift_ready;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    shift_step_a: assert property (pop && pin_sync.clear_n |=>
        shift_reg == {$past(shift_reg[STAGES-2:0]), $past(buf_out_data[0])})
        else $error("shift stage did not advance");

    shift_hold_a: assert property (!pop |=> shift_reg == $past(shift_reg) ||
        shift_reg == '0)
        else $error("shift stages moved without a shift event");

    latch_copy_a: assert property (latch_rise && pin_sync.clear_n |=>
        storage == $past(shift_reg))
        else $error("storage did not take the shift stages");

    clear_zero_a: assert property (!pin_sync.clear_n |=>
        shift_reg == '0 && storage == '0 && sink_oe_n == '1)
        else $error("clear left state behind");

    disable_off_a: assert property (pin_sync.output_enable_n |=> sink_oe_n == '1)
        else $error("sink active while outputs disabled");

    buffer_follow_a: assert property (!pin_sync.output_enable_n && pin_sync.clear_n &&
        !pin_sync.over_temp && thermal == sink_driver_pkg::THERMAL_RUN
        |=> sink_oe_n == ~storage)
        else $error("sinks do not follow storage");

    sink_pins_a: assert property (sink_oe_n == ~sink_on && sink_out == '0)
        else $error("sink pins disagree with output buffer");

    serout_edge_a: assert property ($changed(serial_out) |->
        $past(shift_fall) || $past(!pin_sync.clear_n))
        else $error("serial output moved off a falling edge");

    serout_last_a: assert property (shift_fall && pin_sync.clear_n |=>
        serial_out == $past(shift_reg[STAGES-1]))
        else $error("serial output not from last stage");

    event_kept_a: assert property (shift_rise && pin_sync.clear_n && buf_in_ready
        |-> ##[1:3] pop or ##[1:3] !pin_sync.clear_n)
        else $error("shift event not applied in time");

    thermal_off_a: assert property (pin_sync.over_temp |=>
        thermal == sink_driver_pkg::THERMAL_SHUTDOWN && sink_oe_n == '1)
        else $error("sinks on during over-temperature");
endmodule

// ### common/sink_driver_defines.svh
// constants for the serial shift, latch and sink driver
`ifndef SINK_DRIVER_DEFINES_SVH
`define SINK_DRIVER_DEFINES_SVH
`define SSL_STAGES 12
`define SSL_BUFFER_DEPTH 2
`define SSL_SHIFT_RESET 12'h000
`define SSL_STORE_RESET 12'h000
`define SSL_SERIAL_RESET 1'h0
`define SSL_SYNC_RESET 6'h08
`define SSL_MSB_STAGE 11
`endif

// ### common/sink_driver_pkg.sv
// types shared by the sink driver design files
`include "sink_driver_defines.svh"
package sink_driver_pkg;
    typedef struct packed {
        logic shift_clock;
        logic latch_clock;
        logic clear_n;
        logic output_enable_n;
        logic serial_in;
        logic over_temp;
    } pin_sample_t;

    typedef enum logic [0:0] {
        THERMAL_RUN = 1'h0,
        THERMAL_SHUTDOWN = 1'h1
    } thermal_state_t;

    typedef logic [`SSL_STAGES-1:0] stage_word_t;
endpackage

// ### design/pair_buffer.sv
// small valid/ready buffer with flush, storage in flip-flops
`timescale 1ns/10ps
`include "sink_driver_defines.svh"
module pair_buffer #(
    parameter int WIDTH = 1,
    parameter int DEPTH = `SSL_BUFFER_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] slot [DEPTH];
    logic [WIDTH-1:0] next_slot [DEPTH];
    logic [PW-1:0] head, tail, next_head, next_tail;
    logic [CW-1:0] count, next_count;
    logic next_in_ready;
    logic push, pop;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_valid = (count != '0);
    assign out_data = slot[head];

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    always_comb
    begin
        next_slot = slot;
        next_head = head;
        next_tail = tail;
        next_count = count;
        if (push)
        begin
            next_slot[tail] = in_data;
            next_tail = bump(tail);
        end
        if (pop)
        begin
            next_head = bump(head);
        end
        next_count = CW'(count + CW'(push) - CW'(pop));
        if (flush)
        begin
            next_head = '0;
            next_tail = '0;
            next_count = '0;
        end
        // ready is registered so the source sees a clean level
        next_in_ready = (next_count != CW'(DEPTH));
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            head <= '0;
            tail <= '0;
            count <= '0;
            in_ready <= 1'b1;
            for (int i = 0; i < DEPTH; i++)
            begin
                slot[i] <= '0;
            end
        end
        else
        begin
            head <= next_head;
            tail <= next_tail;
            count <= next_count;
            in_ready <= next_in_ready;
            slot <= next_slot;
        end
    end
endmodule

// ### testbench/host_pin_model.sv
// host model that drives the shift, latch and serial data pins
`timescale 1ns/10ps
module host_pin_model (
    input wire logic start,
    input wire logic shift_en,
    input wire logic latch_en,
    input wire sink_driver_pkg::stage_word_t word,
    input wire logic serial_out,
    output logic shift_clock,
    output logic latch_clock,
    output logic serial_in,
    output logic busy,
    output sink_driver_pkg::stage_word_t seen
);
    initial
    begin
        shift_clock = 1'h0;
        latch_clock = 1'h0;
        serial_in = 1'h0;
        busy = 1'h0;
        seen = 12'h000;
        forever
        begin
            @(posedge start);
            busy = 1'h1;
            // offset keeps every pin change clear of the system clock's rising edges
            #1;
            // shift clock stands still outside frames
            for (int i = 11; i >= 0 && shift_en; i--)
            begin
                serial_in = word[i];
                #62.5;
                seen = {seen[10:0], serial_out};
                shift_clock = 1'h1;
                #62.5;
                shift_clock = 1'h0;
            end
            // no pull on the data line: show the inverse once hold has passed
            serial_in = ~serial_in;
            if (latch_en)
            begin
                #62.5;
                latch_clock = 1'h1;
                #62.5;
                latch_clock = 1'h0;
            end
            #62.5;
            busy = 1'h0;
        end
    end
endmodule

// ### testbench/serial_shift_latch_sink_driver_tb.sv
// self-checking bench for the shift, latch and sink driver
`timescale 1ns/10ps
module serial_shift_latch_sink_driver_tb;
    localparam sink_driver_pkg::stage_word_t WA = 12'hA5C;
    localparam sink_driver_pkg::stage_word_t WB = 12'hBE1;
    localparam sink_driver_pkg::stage_word_t OFF = 12'hFFF;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic clear_n = 1'h0;
    logic output_enable_n = 1'h0;
    logic over_temp = 1'h0;
    logic start = 1'h0;
    logic shift_en = 1'h0;
    logic latch_en = 1'h0;
    sink_driver_pkg::stage_word_t word = 12'h000;
    sink_driver_pkg::stage_word_t seen;
    sink_driver_pkg::stage_word_t sink_out;
    sink_driver_pkg::stage_word_t sink_oe_n;
    logic shift_clock;
    logic latch_clock;
    logic serial_in;
    logic serial_out;
    logic shift_ready;
    logic busy;
    int bad_count = 0;
    int checked = 0;

    serial_shift_latch_sink_driver i_serial_shift_latch_sink_driver (
        .clock(clock), .rst(rst), .shift_clock(shift_clock), .latch_clock(latch_clock),
        .clear_n(clear_n), .output_enable_n(output_enable_n), .serial_in(serial_in),
        .over_temp(over_temp), .sink_out(sink_out), .sink_oe_n(sink_oe_n),
        .serial_out(serial_out), .shift_ready(shift_ready));
    host_pin_model i_host_pin_model (
        .start(start), .shift_en(shift_en), .latch_en(latch_en), .word(word),
        .serial_out(serial_out), .shift_clock(shift_clock), .latch_clock(latch_clock),
        .serial_in(serial_in), .busy(busy), .seen(seen));

    initial
    begin
        forever
            #5 clock = ~clock;
    end

    task automatic check(input logic [11:0] got, input logic [11:0] want, input string what);
        checked++;
        if (got !== want)
        begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task test_done;
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // pin changes reach the outputs three or four edges later
    task settle;
        repeat (6) @(posedge clock);
    endtask

    task automatic frame(input logic [11:0] w, input logic sh, input logic la);
        @(posedge clock);
        word <= w;
        shift_en <= sh;
        latch_en <= la;
        start <= 1'h1;
        @(posedge clock);
        start <= 1'h0;
        for (int n = 0; n < 400 && busy !== 1'h0; n++)
            @(posedge clock);
        settle();
        check({11'h000, shift_ready}, 12'h001, "shift ready");
    endtask

    task t_reset;
        check(sink_oe_n, OFF, "reset sinks");
        check(sink_out, 12'h000, "reset data");
        check({11'h000, serial_out}, 12'h000, "reset serial");
        check({11'h000, shift_ready}, 12'h001, "reset ready");
    endtask

    task t_load;
        frame(WA, 1'h1, 1'h0);
        check(sink_oe_n, OFF, "outputs moved without latch");
        frame(12'h000, 1'h0, 1'h1);
        check(sink_oe_n, ~WA, "latched word");
        check(sink_out, 12'h000, "open drain data");
        check({11'h000, serial_out}, {11'h000, WA[11]}, "last stage");
    endtask

    task t_cascade;
        frame(WB, 1'h1, 1'h1);
        check(seen, WA, "serial out stream");
        check(sink_oe_n, ~WB, "second word");
    endtask

    task t_enable;
        @(posedge clock);
        output_enable_n <= 1'h1;
        settle();
        check(sink_oe_n, OFF, "enable high");
        output_enable_n <= 1'h0;
        settle();
        check(sink_oe_n, ~WB, "enable low");
    endtask

    task t_thermal;
        @(posedge clock);
        over_temp <= 1'h1;
        settle();
        check(sink_oe_n, OFF, "over temperature");
        over_temp <= 1'h0;
        settle();
        check(sink_oe_n, ~WB, "temperature normal");
    endtask

    task t_clear;
        @(posedge clock);
        clear_n <= 1'h0;
        settle();
        check(sink_oe_n, OFF, "clear sinks");
        check({11'h000, serial_out}, 12'h000, "clear serial");
        clear_n <= 1'h1;
        settle();
        check(sink_oe_n, OFF, "storage after clear");
        frame(12'h000, 1'h0, 1'h1);
        check(sink_oe_n, OFF, "shift stages after clear");
    endtask

    initial
    begin
        #100000;
        bad_count++;
        test_done();
    end

    initial
    begin
        repeat (4) @(posedge clock);
        t_reset();
        rst <= 1'h0;
        settle();
        clear_n <= 1'h1;
        settle();
        t_load();
        t_cascade();
        t_enable();
        t_thermal();
        t_clear();
        test_done();
    end
endmodule
